// [design/scf_pkg.sv]
package scf_pkg;
   // Core clock
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned CLK_NS = 20;
   // Frame length limits in bytes
   localparam logic [10:0] LEN_MIN = 11'h040;
   localparam logic [10:0] LEN_STD = 11'h5ee;
   localparam logic [10:0] LEN_LONG = 11'h600;
   localparam logic [10:0] LEN_HUGE = 11'h77c;
   localparam logic [10:0] LEN_VLAN_TAG = 11'h004;
   // Pause quantum is 512 bit times; bit time in ns per speed
   localparam int unsigned QUANTUM_BITS = 512;
   localparam int unsigned BIT_NS_100 = 10;
   localparam int unsigned BIT_NS_10 = 100;
   localparam logic [11:0] QCYC_100 = 12'((QUANTUM_BITS * BIT_NS_100) / CLK_NS);
   localparam logic [11:0] QCYC_10 = 12'((QUANTUM_BITS * BIT_NS_10) / CLK_NS);
   localparam logic [15:0] PAUSE_MAX = 16'hffff;
   localparam logic [15:0] PAUSE_ZERO = 16'h0000;
   // Storm measurement interval
   localparam int unsigned STORM_MS_100 = 50;
   localparam int unsigned STORM_MS_10 = 500;
   localparam int unsigned STORM_CYC_100 = (STORM_MS_100 * 1_000_000) / CLK_NS;
   localparam int unsigned STORM_CYC_10 = (STORM_MS_10 * 1_000_000) / CLK_NS;
   // Back pressure carrier timing
   localparam int unsigned BP_ON_US = 400;
   localparam int unsigned BP_ON_CYC = (BP_ON_US * 1000) / CLK_NS;
   localparam int unsigned BP_SILENT_NS = 960;
   localparam logic [15:0] BP_SILENT_CYC = 16'(BP_SILENT_NS / CLK_NS);
   // Release hysteresis: resources must stay free this long
   localparam int unsigned HYST_US = 10;
   localparam logic [9:0] HYST_CYC = 10'((HYST_US * 1000) / CLK_NS);
   // Register byte addresses
   localparam logic [7:0] ADDR_BACKOFF = 8'h00;
   localparam logic [7:0] ADDR_PORT = 8'h04;
   localparam logic [7:0] ADDR_STORM = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_STORM_CNT = 8'h10;
   // Field positions
   localparam int BIT_AGGR = 0;
   localparam int BIT_STORM_EN = 0;
   localparam int BIT_LONG = 1;
   localparam int BIT_HUGE = 2;
   localparam int BIT_NO_EXC = 3;
   localparam int BIT_BP_EN = 5;
   localparam int BIT_HALF = 6;
   localparam int BIT_SPEED100 = 7;
   localparam int BIT_STORM_MC = 16;
   // Reset values
   localparam logic BACKOFF_RST = 1'b0;
   localparam logic [7:0] PORT_RST = 8'h80;
   localparam logic [10:0] STORM_RATE_RST = 11'h04a;
   localparam logic STORM_MC_RST = 1'b0;
   // Drop reasons
   typedef enum logic [2:0] {
      DROP_NONE, DROP_ERR, DROP_SHORT, DROP_LONG, DROP_PAUSE, DROP_LOCAL, DROP_STORM
   } scf_drop_t;
   // Received frame summary, valid for one cycle at frame end
   typedef struct packed {
      logic valid;
      logic [10:0] len;
      logic vlan;
      logic err_framing;
      logic err_fcs;
      logic err_align;
      logic is_pause;
      logic [15:0] pause_time;
      logic local_dst;
      logic bcast;
      logic mcast;
   } scf_rx_desc_t;
endpackage : scf_pkg

// [design/scf_pause_tmr.sv]
`timescale 1ns/10ps
module scf_pause_tmr
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic load_in,
   input wire logic [15:0] value_in,
   input wire logic quanta_in,
   output logic [15:0] left_out
);
   import scf_pkg::*;

   // A fresh pause value always replaces what is left, even mid count
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         left_out <= PAUSE_ZERO;
      else if (load_in)
         left_out <= value_in;
      else if (quanta_in && left_out != PAUSE_ZERO)
         left_out <= left_out - 16'h0001;
   end
endmodule : scf_pause_tmr

// [design/scf_port_flow.sv]
// Overview of operation
// - Frames shorter than 64 bytes are dropped, never forwarded.
// - A port setting raises the length limit to 1536 bytes.
// - A further setting admits frames up to 1916 bytes.
// - A VLAN tag extends the length limit by the tag bytes.
// - After a received pause, normal transmit waits until the timer expires.
// - A new pause during a running timer reloads it with the new value.
// - While paused only self-generated flow control frames go out.
// - A frame to a busy destination triggers a maximum-time pause frame.
// - When resources free up a zero-time pause frame releases the port.
// - Flow control release uses hysteresis against rapid toggling.
// - A full receive queue flow-controls every port together.
// - Framing, FCS, alignment and size errors are discarded.
// - Received pause frames are consumed locally, not forwarded.
// - Frames whose destination is their own ingress port are dropped.
// - Half-duplex back pressure sends preamble under the same congestion.
// - Forced carrier drops briefly, then returns quickly after a drop.
// - Queued transmit interrupts back pressure; it resumes when queue empties.
// - Collisions under back pressure skip backoff and reassert carrier.
// - Aggressive backoff, no excessive-collision drop, back pressure reset off.
// - One global storm rate, per-port enable, optional multicast counting.
// - Storm counter clears each 50ms (100M) or 500ms (10M) interval.
// - Storm rate limit resets to 0x4A.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module scf_port_flow
#(
   parameter int unsigned STORM_CYC_100_P = scf_pkg::STORM_CYC_100,
   parameter int unsigned STORM_CYC_10_P = scf_pkg::STORM_CYC_10,
   parameter int unsigned BP_ON_CYC_P = scf_pkg::BP_ON_CYC
)
(
   input wire logic SYS_CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   input wire scf_pkg::scf_rx_desc_t RX_DESC_IN,
   input wire logic DEST_BUSY_IN,
   input wire logic RXQ_FULL_IN,
   input wire logic TX_REQ_IN,
   input wire logic TX_BUSY_IN,
   input wire logic COLLISION_IN,
   input wire logic PAUSE_ACK_IN,
   output logic RX_ADMIT_OUT,
   output logic RX_DROP_OUT,
   output scf_pkg::scf_drop_t RX_DROP_CODE_OUT,
   output logic TX_GRANT_OUT,
   output logic PAUSE_REQ_OUT,
   output logic [15:0] PAUSE_VAL_OUT,
   output logic FORCE_CRS_OUT,
   output logic BACKOFF_SKIP_OUT,
   output logic AGGR_BACKOFF_OUT,
   output logic NO_EXC_DROP_OUT
);
   import scf_pkg::*;

   typedef enum {BP_IDLE, BP_CARRIER, BP_SILENT, BP_YIELD} scf_bp_state_t;

   logic rst_meta;
   logic rst_n;
   logic aggr_backoff;
   logic [7:0] port_cfg;
   logic [10:0] storm_rate;
   logic storm_mc;
   logic [10:0] storm_cnt;
   logic [31:0] storm_tmr;
   logic storm_tick;
   logic [11:0] q_cnt;
   logic quanta;
   logic [15:0] pause_left;
   logic pause_take;
   scf_drop_t next_code;
   logic storm_class;
   logic fc_active;
   logic fc_q;
   logic [9:0] free_cnt;
   logic fc_trigger;
   logic res_free;
   logic bp_on;
   scf_bp_state_t bp_state;
   scf_bp_state_t next_bp_state;
   logic [15:0] bp_tmr;
   logic [31:0] next_rdata;
   logic addr_ok;
   logic wr_fire;

   // Longest admitted length for the current settings and tag
   function automatic logic [10:0] max_len(input logic long_en, input logic huge_en,
                                           input logic vlan);
      logic [10:0] base;
      base = huge_en ? LEN_HUGE : (long_en ? LEN_LONG : LEN_STD);
      return vlan ? base + LEN_VLAN_TAG : base;
   endfunction : max_len

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // APB: one wait-free access phase; read data sampled in the setup cycle, write data in the access cycle
   assign wr_fire = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN;
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      addr_ok = 1'b1;
      case (PADDR_IN)
         ADDR_BACKOFF: next_rdata[BIT_AGGR] = aggr_backoff;
         ADDR_PORT: next_rdata[7:0] = port_cfg;
         ADDR_STORM:
         begin
            next_rdata[10:0] = storm_rate;
            next_rdata[BIT_STORM_MC] = storm_mc;
         end
         ADDR_STATUS:
         begin
            next_rdata[0] = fc_active;
            next_rdata[1] = (pause_left != PAUSE_ZERO);
            next_rdata[2] = (bp_state != BP_IDLE);
            next_rdata[31:16] = pause_left;
         end
         ADDR_STORM_CNT: next_rdata[10:0] = storm_cnt;
         default: addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge SYS_CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         PREADY_OUT <= 1'b0;
         PRDATA_OUT <= 32'h0000_0000;
         PSLVERR_OUT <= 1'b0;
      end
      else
      begin
         PREADY_OUT <= PSEL_IN & ~PENABLE_IN;
         PRDATA_OUT <= (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN) ? next_rdata : 32'h0000_0000;
         PSLVERR_OUT <= PSEL_IN & ~PENABLE_IN & ~addr_ok;
      end
   end

   // Writable settings; status registers ignore writes
   always_ff @(posedge SYS_CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aggr_backoff <= BACKOFF_RST;
         port_cfg <= PORT_RST;
         storm_rate <= STORM_RATE_RST;
         storm_mc <= STORM_MC_RST;
      end
      else if (wr_fire)
      begin
         if (PADDR_IN == ADDR_BACKOFF)
            aggr_backoff <= PWDATA_IN[BIT_AGGR];
         if (PADDR_IN == ADDR_PORT)
            port_cfg <= PWDATA_IN[7:0];
         if (PADDR_IN == ADDR_STORM)
         begin
            storm_rate <= PWDATA_IN[10:0];
            storm_mc <= PWDATA_IN[BIT_STORM_MC];
         end
      end
   end

   // Admission decision; errors outrank size, pause, local and storm
   assign storm_class = port_cfg[BIT_STORM_EN] &
                        (RX_DESC_IN.bcast | (RX_DESC_IN.mcast & storm_mc));
   always_comb
   begin
      next_code = DROP_NONE;
      if (RX_DESC_IN.err_framing | RX_DESC_IN.err_fcs | RX_DESC_IN.err_align)
         next_code = DROP_ERR;
      else if (RX_DESC_IN.len < LEN_MIN)
         next_code = DROP_SHORT;
      else if (RX_DESC_IN.len > max_len(port_cfg[BIT_LONG], port_cfg[BIT_HUGE],
                                        RX_DESC_IN.vlan))
         next_code = DROP_LONG;
      else if (RX_DESC_IN.is_pause)
         next_code = DROP_PAUSE;
      else if (RX_DESC_IN.local_dst)
         next_code = DROP_LOCAL;
      else if (storm_class && storm_cnt >= storm_rate)
         next_code = DROP_STORM;
   end

   always_ff @(posedge SYS_CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         RX_ADMIT_OUT <= 1'b0;
         RX_DROP_OUT <= 1'b0;
         RX_DROP_CODE_OUT <= DROP_NONE;
      end
      else
      begin
         RX_ADMIT_OUT <= RX_DESC_IN.valid & (next_code == DROP_NONE);
         RX_DROP_OUT <= RX_DESC_IN.valid & (next_code != DROP_NONE);
         RX_DROP_CODE_OUT <= RX_DESC_IN.valid ? next_code : DROP_NONE;
      end
   end

   // Storm interval timer; its length follows the link speed
   assign storm_tick = (storm_tmr == 32'(port_cfg[BIT_SPEED100] ? STORM_CYC_100_P - 1
                                                             : STORM_CYC_10_P - 1));
   always_ff @(posedge SYS_CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
         storm_tmr <= 32'h0000_0000;
      else if (storm_tick)
         storm_tmr <= 32'h0000_0000;
      else
         storm_tmr <= storm_tmr + 32'h0000_0001;
   end

   // Frame counter; a frame landing on the tick counts in the new interval
   always_ff @(posedge SYS_CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
         storm_cnt <= 11'h000;
      else if (storm_tick)
         storm_cnt <= (RX_DESC_IN.valid && storm_class && next_code == DROP_NONE)
                      ? 11'h001 : 11'h000;
      else if (RX_DESC_IN.valid && storm_class && next_code == DROP_NONE)
         storm_cnt <= storm_cnt + 11'h001;
   end

   // Pause quantum divider, 512 bit times at the current speed
   assign quanta = (q_cnt == (port_cfg[BIT_SPEED100] ? QCYC_100 : QCYC_10) - 12'h001);
   always_ff @(posedge SYS_CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
         q_cnt <= 12'h000;
      else if (quanta)
         q_cnt <= 12'h000;
      else
         q_cnt <= q_cnt + 12'h001;
   end

   // Received pause loads the timer and never leaves the port
   assign pause_take = RX_DESC_IN.valid & (next_code == DROP_PAUSE);
   scf_pause_tmr u_pause_tmr
   (
      .clk_in(SYS_CLK_IN),
      .rst_n_in(rst_n),
      .load_in(pause_take),
      .value_in(RX_DESC_IN.pause_time),
      .quanta_in(quanta),
      .left_out(pause_left)
   );

   // Congestion: busy destination on a fresh frame, or a full receive queue
   assign fc_trigger = (RX_DESC_IN.valid & (next_code == DROP_NONE) & DEST_BUSY_IN) |
                       RXQ_FULL_IN;
   assign res_free = ~DEST_BUSY_IN & ~RXQ_FULL_IN;
   // Release only after resources stay free for the whole hold time
   always_ff @(posedge SYS_CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
         free_cnt <= 10'h000;
      else if (!fc_active || !res_free)
         free_cnt <= 10'h000;
      else if (free_cnt != HYST_CYC - 10'h001)
         free_cnt <= free_cnt + 10'h001;
   end

   always_ff @(posedge SYS_CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fc_active <= 1'b0;
         fc_q <= 1'b0;
      end
      else
      begin
         fc_q <= fc_active;
         if (fc_trigger)
            fc_active <= 1'b1;
         else if (res_free && free_cnt == HYST_CYC - 10'h001)
            fc_active <= 1'b0;
      end
   end

   // Pause frame request; a new edge wins over an ack in the same cycle
   always_ff @(posedge SYS_CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         PAUSE_REQ_OUT <= 1'b0;
         PAUSE_VAL_OUT <= PAUSE_ZERO;
      end
      else if (!port_cfg[BIT_HALF] && fc_active != fc_q)
      begin
         PAUSE_REQ_OUT <= 1'b1;
         PAUSE_VAL_OUT <= fc_active ? PAUSE_MAX : PAUSE_ZERO;
      end
      else if (PAUSE_ACK_IN)
         PAUSE_REQ_OUT <= 1'b0;
   end

   // Half-duplex back pressure state machine
   assign bp_on = port_cfg[BIT_HALF] & port_cfg[BIT_BP_EN] & fc_active;
   always_comb
   begin
      next_bp_state = bp_state;
      case (bp_state)
         BP_IDLE:
            if (bp_on)
               next_bp_state = BP_CARRIER;
         BP_CARRIER:
            if (TX_REQ_IN)
               next_bp_state = BP_YIELD;
            else if (!COLLISION_IN && bp_tmr >= 16'(BP_ON_CYC_P - 1))
               next_bp_state = BP_SILENT;
         BP_SILENT:
            if (RX_DESC_IN.valid || COLLISION_IN || bp_tmr == BP_SILENT_CYC - 16'h0001)
               next_bp_state = BP_CARRIER;
         BP_YIELD:
            if (!TX_REQ_IN && !TX_BUSY_IN)
               next_bp_state = BP_CARRIER;
         default: next_bp_state = BP_IDLE;
      endcase
      if (!bp_on)
         next_bp_state = BP_IDLE;
   end

   // The carrier timer restarts on every state change
   always_ff @(posedge SYS_CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bp_state <= BP_IDLE;
         bp_tmr <= 16'h0000;
      end
      else
      begin
         bp_state <= next_bp_state;
         bp_tmr <= (next_bp_state != bp_state) ? 16'h0000 : bp_tmr + 16'h0001;
      end
   end

   // Transmit side outputs; pause frames bypass the grant
   always_ff @(posedge SYS_CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         TX_GRANT_OUT <= 1'b0;
         FORCE_CRS_OUT <= 1'b0;
         BACKOFF_SKIP_OUT <= 1'b0;
         AGGR_BACKOFF_OUT <= BACKOFF_RST;
         NO_EXC_DROP_OUT <= 1'b0;
      end
      else
      begin
         TX_GRANT_OUT <= (pause_left == PAUSE_ZERO) &
                         (bp_state != BP_CARRIER) & (bp_state != BP_SILENT);
         FORCE_CRS_OUT <= (bp_state == BP_CARRIER);
         BACKOFF_SKIP_OUT <= (bp_state != BP_IDLE);
         AGGR_BACKOFF_OUT <= aggr_backoff;
         NO_EXC_DROP_OUT <= port_cfg[BIT_NO_EXC];
      end
   end

   property p_short;
      @(posedge SYS_CLK_IN) disable iff (!rst_n)
      RX_DESC_IN.valid && RX_DESC_IN.len < LEN_MIN |=> RX_DROP_OUT && !RX_ADMIT_OUT;
   endproperty
   a_short: assert property (p_short) else $error("short frame not dropped");

   property p_long_ok;
      @(posedge SYS_CLK_IN) disable iff (!rst_n)
      RX_DESC_IN.valid && port_cfg[BIT_LONG] && !RX_DESC_IN.vlan && RX_DESC_IN.len == LEN_LONG
      |=> RX_DROP_CODE_OUT != DROP_LONG;
   endproperty
   a_long_ok: assert property (p_long_ok) else $error("1536 frame refused");

   property p_huge;
      @(posedge SYS_CLK_IN) disable iff (!rst_n)
      RX_DESC_IN.valid && port_cfg[BIT_HUGE] && !RX_DESC_IN.vlan
      ##0 (RX_DESC_IN.len == LEN_HUGE + 11'h001 || RX_DESC_IN.len == LEN_HUGE)
      |=> (RX_DROP_CODE_OUT == DROP_LONG) == ($past(RX_DESC_IN.len) == LEN_HUGE + 11'h001 &&
                                             !$past(next_code == DROP_ERR));
   endproperty
   a_huge: assert property (p_huge) else $error("1916 limit wrong");

   property p_vlan;
      @(posedge SYS_CLK_IN) disable iff (!rst_n)
      RX_DESC_IN.valid && RX_DESC_IN.vlan && !port_cfg[BIT_LONG] && !port_cfg[BIT_HUGE] &&
      RX_DESC_IN.len == LEN_STD + LEN_VLAN_TAG |=> RX_DROP_CODE_OUT != DROP_LONG;
   endproperty
   a_vlan: assert property (p_vlan) else $error("tagged frame limit not extended");

   property p_pause_hold;
      @(posedge SYS_CLK_IN) disable iff (!rst_n)
      pause_left != 16'h0000 |=> !TX_GRANT_OUT;
   endproperty
   a_pause_hold: assert property (p_pause_hold) else $error("grant while paused");

   property p_reload;
      @(posedge SYS_CLK_IN) disable iff (!rst_n)
      pause_take |=> pause_left == $past(RX_DESC_IN.pause_time);
   endproperty
   a_reload: assert property (p_reload) else $error("pause timer not reloaded");

   property p_xoff;
      @(posedge SYS_CLK_IN) disable iff (!rst_n)
      $rose(fc_active) && !port_cfg[BIT_HALF] |=> PAUSE_REQ_OUT && PAUSE_VAL_OUT == 16'hffff;
   endproperty
   a_xoff: assert property (p_xoff) else $error("no maximum pause on congestion");

   property p_xon;
      @(posedge SYS_CLK_IN) disable iff (!rst_n)
      $fell(fc_active) && !port_cfg[BIT_HALF] |=> PAUSE_REQ_OUT && PAUSE_VAL_OUT == 16'h0000;
   endproperty
   a_xon: assert property (p_xon) else $error("no zero pause on release");

   property p_hyst;
      @(posedge SYS_CLK_IN) disable iff (!rst_n)
      $fell(fc_active) |-> $past(res_free, 2) && $past(free_cnt) == HYST_CYC - 10'h001;
   endproperty
   a_hyst: assert property (p_hyst) else $error("release without hold time");

   property p_rxq;
      @(posedge SYS_CLK_IN) disable iff (!rst_n)
      RXQ_FULL_IN |=> fc_active;
   endproperty
   a_rxq: assert property (p_rxq) else $error("full queue not flow controlled");

   property p_err;
      @(posedge SYS_CLK_IN) disable iff (!rst_n)
      RX_DESC_IN.valid && (RX_DESC_IN.err_fcs || RX_DESC_IN.err_align || RX_DESC_IN.err_framing)
      |=> RX_DROP_CODE_OUT == DROP_ERR && !RX_ADMIT_OUT;
   endproperty
   a_err: assert property (p_err) else $error("error frame admitted");

   property p_local;
      @(posedge SYS_CLK_IN) disable iff (!rst_n)
      RX_DESC_IN.valid && RX_DESC_IN.local_dst |=> !RX_ADMIT_OUT;
   endproperty
   a_local: assert property (p_local) else $error("local frame forwarded");

   property p_bp_crs;
      @(posedge SYS_CLK_IN) disable iff (!rst_n)
      bp_state == BP_CARRIER ##1 bp_on |-> FORCE_CRS_OUT ##1 (bp_state != BP_IDLE);
   endproperty
   a_bp_crs: assert property (p_bp_crs) else $error("carrier not forced");

   property p_silent;
      @(posedge SYS_CLK_IN) disable iff (!rst_n)
      bp_state == BP_SILENT && bp_on && (RX_DESC_IN.valid || COLLISION_IN)
      |=> bp_state == BP_CARRIER ##1 FORCE_CRS_OUT;
   endproperty
   a_silent: assert property (p_silent) else $error("carrier not reasserted");

   property p_yield;
      @(posedge SYS_CLK_IN) disable iff (!rst_n)
      bp_state == BP_CARRIER && bp_on && TX_REQ_IN |=> bp_state == BP_YIELD;
   endproperty
   a_yield: assert property (p_yield) else $error("queued frame kept waiting");

   property p_storm;
      @(posedge SYS_CLK_IN) disable iff (!rst_n)
      storm_tick |=> storm_cnt <= 11'h001;
   endproperty
   a_storm: assert property (p_storm) else $error("storm counter not cleared");
endmodule : scf_port_flow

// [test/scf_remote_mac.sv]
`timescale 1ns/10ps
// Far-end MAC: takes each pause request after a few cycles, never at once
module scf_remote_mac
#(
   parameter int DLY = 4
)
(
   input wire logic clk_in,
   input wire logic req_in,
   output logic ack_out
);
   int cnt = 0;
   logic ack_q = 1'b0;
   assign ack_out = ack_q;
   // One ack pulse per request; a request left standing is taken again later
   always @(posedge clk_in)
   begin
      ack_q <= 1'b0;
      if (!req_in || ack_q)
         cnt <= 0;
      else if (cnt == DLY)
         ack_q <= 1'b1;
      else
         cnt <= cnt + 1;
   end
endmodule : scf_remote_mac

// [test/testbench.sv]
`timescale 1ns/10ps
module testbench;
   import scf_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, busy = 1'b0, full = 1'b0;
   logic txr = 1'b0, col = 1'b0, bc = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, admit, drop, grant, preq, crs, skip, aggr, noexc, ack, err;
   logic [15:0] pval;
   scf_drop_t code;
   scf_rx_desc_t d = '0;
   int failures = 0, tests_run = 0, cyc = 0;
   // Short storm and carrier counts keep the run brief
   scf_port_flow #(.STORM_CYC_100_P(200), .STORM_CYC_10_P(2000), .BP_ON_CYC_P(100))
   u_scf_port_flow (
      .SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .RX_DESC_IN(d), .DEST_BUSY_IN(busy),
      .RXQ_FULL_IN(full), .TX_REQ_IN(txr), .TX_BUSY_IN(1'b0), .COLLISION_IN(col),
      .PAUSE_ACK_IN(ack), .RX_ADMIT_OUT(admit), .RX_DROP_OUT(drop),
      .RX_DROP_CODE_OUT(code), .TX_GRANT_OUT(grant), .PAUSE_REQ_OUT(preq),
      .PAUSE_VAL_OUT(pval), .FORCE_CRS_OUT(crs), .BACKOFF_SKIP_OUT(skip),
      .AGGR_BACKOFF_OUT(aggr), .NO_EXC_DROP_OUT(noexc));
   scf_remote_mac u_scf_remote_mac (.clk_in(clk), .req_in(preq), .ack_out(ack));
   // 50 MHz core clock
   initial
   begin
      forever #10 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         failures = failures + 1;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : w
   // APB cycle; waits for pready however long it takes
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   // Frame summary; f = {local, pause, fcs error, vlan}; bc marks broadcast
   task automatic frm(input int len, input logic [3:0] f, input logic [15:0] pt,
                      input scf_drop_t ex);
      scf_rx_desc_t t;
      t = '0;
      t.valid = 1'b1;
      t.len = len[10:0];
      t.vlan = f[0];
      t.err_fcs = f[1];
      t.is_pause = f[2];
      t.local_dst = f[3];
      t.bcast = bc;
      t.pause_time = pt;
      @(posedge clk);
      d <= t;
      @(posedge clk);
      d.valid <= 1'b0;
      #1;
      chk(32'({admit, drop}), 32'(ex == DROP_NONE ? 2'b10 : 2'b01));
      chk(32'(code), 32'(ex));
   endtask : frm
   initial
   begin
      w(5);
      rst_n <= 1'b1;
      w(3);
      apb(1'b0, ADDR_PORT, 32'h0);
      chk(rd, 32'h80);
      apb(1'b0, ADDR_STORM, 32'h0);
      chk(rd, 32'h4a);
      apb(1'b0, ADDR_BACKOFF, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk(32'(err), 32'h1);
      apb(1'b1, ADDR_BACKOFF, 32'h1);
      apb(1'b1, ADDR_PORT, 32'h88);
      w(1);
      chk(32'({aggr, noexc}), 32'h3);
      $display("registers done");
      frm(63, 4'h0, 16'h0, DROP_SHORT);
      frm(64, 4'h0, 16'h0, DROP_NONE);
      frm(1519, 4'h0, 16'h0, DROP_LONG);
      frm(1522, 4'h1, 16'h0, DROP_NONE);
      frm(1523, 4'h1, 16'h0, DROP_LONG);
      frm(64, 4'h2, 16'h0, DROP_ERR);
      frm(64, 4'h8, 16'h0, DROP_LOCAL);
      apb(1'b1, ADDR_PORT, 32'h8a);
      frm(1536, 4'h0, 16'h0, DROP_NONE);
      frm(1537, 4'h0, 16'h0, DROP_LONG);
      apb(1'b1, ADDR_PORT, 32'h8c);
      frm(1916, 4'h0, 16'h0, DROP_NONE);
      frm(1917, 4'h0, 16'h0, DROP_LONG);
      $display("lengths done");
      // Limit of two broadcasts per interval, counting aligned to a fresh interval
      apb(1'b1, ADDR_STORM, 32'h2);
      apb(1'b1, ADDR_PORT, 32'h8d);
      bc = 1'b1;
      frm(64, 4'h0, 16'h0, DROP_NONE);
      do
         apb(1'b0, ADDR_STORM_CNT, 32'h0);
      while (rd !== 32'h0);
      frm(64, 4'h0, 16'h0, DROP_NONE);
      frm(64, 4'h0, 16'h0, DROP_NONE);
      frm(64, 4'h0, 16'h0, DROP_STORM);
      w(200);
      frm(64, 4'h0, 16'h0, DROP_NONE);
      bc = 1'b0;
      $display("storm done");
      // Two quanta cannot run out in 2 cycles; three reloaded ones outlast the first timer
      frm(64, 4'h4, 16'h2, DROP_PAUSE);
      w(2);
      chk(32'(grant), 32'h0);
      w(100);
      frm(64, 4'h4, 16'h3, DROP_PAUSE);
      w(450);
      chk(32'(grant), 32'h0);
      w(400);
      chk(32'(grant), 32'h1);
      $display("pause done");
      busy <= 1'b1;
      frm(64, 4'h0, 16'h0, DROP_NONE);
      w(2);
      chk(32'({preq, pval}), 32'h1ffff);
      busy <= 1'b0;
      w(300);
      chk(32'(pval), 32'hffff);
      w(300);
      chk(32'(pval), 32'h0);
      full <= 1'b1;
      w(3);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(32'(rd[0]), 32'h1);
      apb(1'b1, ADDR_PORT, 32'he8);
      w(5);
      chk(32'({crs, skip}), 32'h3);
      // Carrier phase is 100 cycles, then a silent gap that a collision cuts short
      w(100);
      chk(32'(crs), 32'h0);
      col <= 1'b1;
      w(1);
      col <= 1'b0;
      w(2);
      chk(32'(crs), 32'h1);
      txr <= 1'b1;
      w(2);
      chk(32'({grant, crs}), 32'h2);
      txr <= 1'b0;
      w(2);
      chk(32'({grant, crs}), 32'h1);
      $display("congestion done");
      end_sim();
   end
endmodule : testbench
